// >>> hw/ret_rot_exec.sv
// executes or-into-memory, returns and rotate-left for the core
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// - or_into_memory writes acc OR mem byte back and updates zero.
// - a plain return pops the pc from the stack, flags untouched.
// - return-with-load pops the pc and loads the immediate into acc.
// - interrupt_return pops the pc and sets global_interrupt_enable.
// - a pending interrupt at interrupt_return is taken before resuming.
// - rotate_left_memory moves bit i to i+1 and bit 7 into bit 0.
module ret_rot_exec
    import ret_rot_pkg::*;
#(
    parameter int PCW = PC_W,
    parameter int DEPTH = STACK_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // instruction from decoder
    input wire logic op_valid,
    input wire logic [OP_W-1:0] op_code,
    input wire logic [ADDR_W-1:0] op_addr,
    input wire logic [DATA_W-1:0] op_imm,
    output logic op_ready_q,
    // subroutine call push from the core
    input wire logic call_push,
    input wire logic [PCW-1:0] call_ret_pc,
    // interrupt request, already in core_clk domain
    input wire logic irq_pending,
    // data memory, one cycle read latency
    output logic mem_rd_q,
    output logic mem_wr_q,
    output logic [ADDR_W-1:0] mem_addr_q,
    output logic [DATA_W-1:0] mem_wdata_q,
    input wire logic [DATA_W-1:0] mem_rdata,
    // architectural state
    output logic [PCW-1:0] pc_q,
    output logic pc_load_q,
    output logic [DATA_W-1:0] acc_q,
    output logic zero_q,
    output logic global_interrupt_enable_q,
    output logic irq_taken_q
);
    initial begin
        if (PCW < 4 || PCW > PC_W)
            $error("ret_rot_exec: PCW out of range");
    end

    function automatic logic [DATA_W-1:0] rot_left(
        input logic [DATA_W-1:0] v);
        rot_left = {v[DATA_W-2:0], v[DATA_W-1]};
    endfunction : rot_left

    ////////////////////////////////////////////////////////////////////////////
    logic [PCW-1:0] stack_top;
    logic push, pop;
    logic [PCW-1:0] push_data;

    ret_stack #(
        .WIDTH(PCW),
        .DEPTH(DEPTH)
    ) i_ret_stack (
        .core_clk(core_clk),
        .nrst(nrst),
        .push(push),
        .push_data(push_data),
        .pop(pop),
        .top_q(stack_top),
        .empty_q()
    );

    ////////////////////////////////////////////////////////////////////////////
    // sequencer: decode, stack pop and memory read-modify-write
    state_t state_q, state_d;
    op_t mop_q, mop_d;
    logic op_ready_d, rd_d, wr_d;
    logic [ADDR_W-1:0] addr_d;
    logic [DATA_W-1:0] wdata_d;
    logic [DATA_W-1:0] res;
    logic ret_go, load_go, iret_go, vector_go, or_done;
    op_t op;

    always_comb begin
        op = op_t'(op_code);
        state_d = state_q;
        mop_d = mop_q;
        op_ready_d = op_ready_q;
        rd_d = 1'b0;
        wr_d = 1'b0;
        addr_d = mem_addr_q;
        wdata_d = mem_wdata_q;
        push = call_push;
        push_data = call_ret_pc;
        pop = 1'b0;
        res = '0;
        ret_go = 1'b0;
        load_go = 1'b0;
        iret_go = 1'b0;
        vector_go = 1'b0;
        or_done = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                op_ready_d = 1'b1;
                if (op_valid && op_ready_q) begin
                    unique case (op)
                        OP_OR_INTO_MEMORY, OP_ROTATE_LEFT_MEMORY: begin
                            mop_d = op;
                            addr_d = op_addr;
                            rd_d = 1'b1;
                            op_ready_d = 1'b0;
                            state_d = ST_MEM_WAIT;
                        end
                        OP_RETURN: begin
                            ret_go = 1'b1;
                            pop = 1'b1;
                        end
                        OP_RETURN_LOAD: begin
                            load_go = 1'b1;
                            pop = 1'b1;
                        end
                        OP_INTERRUPT_RETURN: begin
                            iret_go = 1'b1;
                            // return address stays on stack when vectoring
                            vector_go = irq_pending;
                            pop = !irq_pending;
                        end
                        default: ;
                    endcase
                end
            end
            ST_MEM_WAIT: state_d = ST_MEM_WRITE;
            ST_MEM_WRITE: begin
                if (mop_q == OP_OR_INTO_MEMORY) begin
                    res = acc_q | mem_rdata;
                    or_done = 1'b1;
                end else begin
                    res = rot_left(mem_rdata);
                end
                wdata_d = res;
                wr_d = 1'b1;
                op_ready_d = 1'b1;
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            mop_q <= OP_NONE;
            op_ready_q <= 1'b0;
            mem_rd_q <= 1'b0;
            mem_wr_q <= 1'b0;
            mem_addr_q <= '0;
            mem_wdata_q <= '0;
        end else begin
            state_q <= state_d;
            mop_q <= mop_d;
            op_ready_q <= op_ready_d;
            mem_rd_q <= rd_d;
            mem_wr_q <= wr_d;
            mem_addr_q <= addr_d;
            mem_wdata_q <= wdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // architectural state: pc, accumulator, zero flag, interrupt enable
    logic [PCW-1:0] pc_d;
    logic pc_load_d, irq_d;
    logic [DATA_W-1:0] acc_d;
    logic zero_d, gie_d;

    always_comb begin
        pc_d = pc_q;
        pc_load_d = 1'b0;
        acc_d = acc_q;
        zero_d = zero_q;
        gie_d = global_interrupt_enable_q;
        irq_d = 1'b0;
        if (ret_go || load_go) begin
            pc_d = stack_top;
            pc_load_d = 1'b1;
        end
        if (load_go) begin
            acc_d = op_imm;
        end
        if (iret_go) begin
            pc_load_d = 1'b1;
            if (vector_go) begin
                pc_d = IRQ_VECTOR[PCW-1:0];
                gie_d = 1'b0;
                irq_d = 1'b1;
            end else begin
                pc_d = stack_top;
                gie_d = 1'b1;
            end
        end
        if (or_done) begin
            zero_d = (res == '0);
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pc_q <= PC_RST[PCW-1:0];
            pc_load_q <= 1'b0;
            acc_q <= ACC_RST;
            zero_q <= ZERO_RST;
            global_interrupt_enable_q <= GIE_RST;
            irq_taken_q <= 1'b0;
        end else begin
            pc_q <= pc_d;
            pc_load_q <= pc_load_d;
            acc_q <= acc_d;
            zero_q <= zero_d;
            global_interrupt_enable_q <= gie_d;
            irq_taken_q <= irq_d;
        end
    end
endmodule : ret_rot_exec

// >>> include/ret_rot_pkg.sv
// constants and types for the return/rotate execution block
package ret_rot_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int ADDR_W = 8;
    localparam int STACK_DEPTH = 8;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic ZERO_RST = 1'b0;
    localparam logic GIE_RST = 1'b0;
    localparam logic [PC_W-1:0] PC_RST = 13'h0000;
    localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
    localparam int OP_W = 3;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_OR_INTO_MEMORY,
        OP_RETURN,
        OP_RETURN_LOAD,
        OP_INTERRUPT_RETURN,
        OP_ROTATE_LEFT_MEMORY
    } op_t;

    typedef enum {
        ST_IDLE,
        ST_MEM_WAIT,
        ST_MEM_WRITE
    } state_t;
endpackage : ret_rot_pkg

// >>> hw/ret_stack.sv
// return address stack with registered read data
`timescale 1ns/1ps
module ret_stack
    import ret_rot_pkg::*;
#(
    parameter int WIDTH = PC_W,
    parameter int DEPTH = STACK_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // push and pop
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] top_q,
    output logic empty_q
);
    localparam int PW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH)
            $error("ret_stack: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] ptr_q, ptr_d;
    logic [PW:0] cnt_q, cnt_d;
    logic [WIDTH-1:0] top_d;

    always_comb begin
        ptr_d = ptr_q;
        cnt_d = cnt_q;
        top_d = top_q;
        if (push) begin
            ptr_d = ptr_q + 1'b1;
            if (cnt_q != (PW+1)'(DEPTH))
                cnt_d = cnt_q + 1'b1;
            top_d = push_data;
        end else if (pop) begin
            ptr_d = ptr_q - 1'b1;
            if (cnt_q != '0)
                cnt_d = cnt_q - 1'b1;
            top_d = mem_q[ptr_q - 1'b1];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ptr_q <= '0;
            cnt_q <= '0;
            top_q <= '0;
            empty_q <= 1'b1;
        end else begin
            ptr_q <= ptr_d;
            cnt_q <= cnt_d;
            top_q <= top_d;
            empty_q <= (cnt_d == '0);
        end
    end

    // storage without reset; slot ptr-1 holds the word under the top
    always_ff @(posedge core_clk) begin
        if (push)
            mem_q[ptr_q] <= top_q;
    end
endmodule : ret_stack

// >>> sim/ret_rot_exec_assertions.sv
// checker for the return and rotate execution block
`timescale 1ns/1ps
module ret_rot_exec_assertions
    import ret_rot_pkg::*;
#(
    parameter int PCW = PC_W
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // instruction
    input wire logic op_valid,
    input wire logic [OP_W-1:0] op_code,
    input wire logic [ADDR_W-1:0] op_addr,
    input wire logic [DATA_W-1:0] op_imm,
    input wire logic op_ready_q,
    input wire logic irq_pending,
    // data memory
    input wire logic mem_rd_q,
    input wire logic mem_wr_q,
    input wire logic [ADDR_W-1:0] mem_addr_q,
    input wire logic [DATA_W-1:0] mem_wdata_q,
    input wire logic [DATA_W-1:0] mem_rdata,
    // state
    input wire logic [PCW-1:0] pc_q,
    input wire logic pc_load_q,
    input wire logic [DATA_W-1:0] acc_q,
    input wire logic zero_q,
    input wire logic global_interrupt_enable_q,
    input wire logic irq_taken_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic go;
    assign go = op_valid && op_ready_q;
    a_mem_rd_start: assert property (go && (op_code == OP_OR_INTO_MEMORY
        || op_code == OP_ROTATE_LEFT_MEMORY) |=> mem_rd_q && !op_ready_q
        && mem_addr_q == $past(op_addr) ##2 op_ready_q) else $error("rd");
    a_or_write_zero: assert property (go && op_code == OP_OR_INTO_MEMORY
        |-> ##3 mem_wr_q && mem_wdata_q == (acc_q | $past(mem_rdata))
        && zero_q == (mem_wdata_q == 8'h00)) else $error("or");
    a_rot_write: assert property (go && op_code == OP_ROTATE_LEFT_MEMORY
        |-> ##3 mem_wr_q && $stable(zero_q)
        && mem_wdata_q == {$past(mem_rdata[6:0]), $past(mem_rdata[7])})
        else $error("rot");
    a_ret_flags: assert property (go && op_code == OP_RETURN
        |=> pc_load_q && $stable(zero_q) && $stable(acc_q)) else $error("ret");
    a_ret_load_acc: assert property (go && op_code == OP_RETURN_LOAD
        |=> pc_load_q && acc_q == $past(op_imm)) else $error("retl");
    a_iret_gie: assert property (go && op_code == OP_INTERRUPT_RETURN
        && !irq_pending |=> pc_load_q && global_interrupt_enable_q
        && !irq_taken_q) else $error("iret");
    a_iret_pending: assert property (go && irq_pending
        && op_code == OP_INTERRUPT_RETURN |=> irq_taken_q
        && pc_q == IRQ_VECTOR && !global_interrupt_enable_q) else $error("irq");
    a_wr_has_cause: assert property (mem_wr_q |-> $past(mem_rd_q, 2))
        else $error("wr");
endmodule : ret_rot_exec_assertions
bind ret_rot_exec ret_rot_exec_assertions #(.PCW(PCW)) i_chk (.core_clk,
    .nrst, .op_valid, .op_code, .op_addr, .op_imm, .op_ready_q, .irq_pending,
    .mem_rd_q, .mem_wr_q, .mem_addr_q, .mem_wdata_q, .mem_rdata, .pc_q,
    .pc_load_q, .acc_q, .zero_q, .global_interrupt_enable_q, .irq_taken_q);

// >>> sim/ret_rot_exec_tb_top.sv
// self-checking testbench for the return and rotate execution block
`timescale 1ns/1ps
module ret_rot_exec_tb_top import ret_rot_pkg::*; ;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic op_valid = 1'b0;
    logic call_push = 1'b0;
    logic irq_pending = 1'b0;
    logic [OP_W-1:0] op_code = 3'h0;
    logic [7:0] op_addr = 8'h00;
    logic [7:0] op_imm = 8'h00;
    logic [7:0] mem_rdata = 8'h00;
    logic [PC_W-1:0] call_ret_pc = 13'h0000;
    logic op_ready_q, mem_rd_q, mem_wr_q, pc_load_q, zero_q, irq_taken_q;
    logic global_interrupt_enable_q;
    logic [7:0] mem_addr_q, mem_wdata_q, acc_q;
    logic [PC_W-1:0] pc_q;
    int n_errors = 0;
    int n_tests = 0;
    always #20 core_clk = ~core_clk;
    ret_rot_exec i_ret_rot_exec (.core_clk, .nrst, .op_valid, .op_code,
        .op_addr, .op_imm, .op_ready_q, .call_push, .call_ret_pc, .irq_pending,
        .mem_rd_q, .mem_wr_q, .mem_addr_q, .mem_wdata_q, .mem_rdata, .pc_q,
        .pc_load_q, .acc_q, .zero_q, .global_interrupt_enable_q, .irq_taken_q);
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done;
        if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask : tick
    task automatic push(input logic [PC_W-1:0] v);
        call_ret_pc = v;
        call_push = 1'b1;
        tick();
        call_push = 1'b0;
        tick();
    endtask : push
    // leaves op_valid high so returns can follow back to back
    task automatic issue(input op_t op, input logic [7:0] a, imm);
        int i;
        op_valid = 1'b1;
        op_code = op;
        op_addr = a;
        op_imm = imm;
        for (i = 0; i < 10 && op_ready_q !== 1'b1; i++) tick();
        if (i == 10) begin
            n_errors++;
            test_done();
        end
        tick();
    endtask : issue
    task automatic idle;
        op_valid = 1'b0;
        tick();
    endtask : idle
    task automatic mem_op(input op_t op, input logic [7:0] a, d, w, z);
        int i;
        mem_rdata = ~d;
        issue(op, a, 8'h00);
        op_valid = 1'b0;
        check(mem_rd_q, 1'b1);
        check(mem_addr_q, a);
        tick();
        // read data stands from the cycle after the read strobe until the write strobe is checked
        mem_rdata = d;
        for (i = 0; i < 4 && mem_wr_q !== 1'b1; i++) tick();
        if (i == 4) begin
            n_errors++;
            test_done();
        end
        check(mem_wr_q, 1'b1);
        check(mem_wdata_q, w);
        check(zero_q, z);
        mem_rdata = ~d;
        tick();
    endtask : mem_op
    ////////////////////////////////////////////////////////////////////////
    task automatic t_returns;
        push(13'h0123);
        push(13'h1ABC);
        issue(OP_RETURN, 8'h00, 8'h5A);
        check(pc_q, 13'h1ABC);
        check({acc_q, zero_q}, {ACC_RST, ZERO_RST});
        issue(OP_RETURN_LOAD, 8'h00, 8'hC3);
        check(pc_load_q, 1'b1);
        check({pc_q, acc_q}, {13'h0123, 8'hC3});
        idle();
    endtask : t_returns
    task automatic t_memory;
        push(13'h0010);
        issue(OP_RETURN_LOAD, 8'h00, 8'h00);
        idle();
        mem_op(OP_OR_INTO_MEMORY, 8'h20, 8'h00, 8'h00, 1'b1);
        mem_op(OP_ROTATE_LEFT_MEMORY, 8'h07, 8'h81, 8'h03, 1'b1);
        push(13'h0011);
        issue(OP_RETURN_LOAD, 8'h00, 8'h5A);
        idle();
        mem_op(OP_OR_INTO_MEMORY, 8'hFF, 8'hA1, 8'hFB, 1'b0);
        mem_op(OP_ROTATE_LEFT_MEMORY, 8'h80, 8'h00, 8'h00, 1'b0);
    endtask : t_memory
    task automatic t_interrupt_return;
        push(13'h0555);
        issue(OP_INTERRUPT_RETURN, 8'h00, 8'h00);
        check(pc_q, 13'h0555);
        check(global_interrupt_enable_q, 1'b1);
        idle();
        push(13'h0AAA);
        irq_pending = 1'b1;
        issue(OP_INTERRUPT_RETURN, 8'h00, 8'h00);
        check({irq_taken_q, pc_q}, {1'b1, IRQ_VECTOR});
        check(global_interrupt_enable_q, 1'b0);
        irq_pending = 1'b0;
        issue(OP_RETURN, 8'h00, 8'h00);
        check(pc_q, 13'h0AAA);
        idle();
    endtask : t_interrupt_return
    initial begin
        repeat (20) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        tick();
        t_returns();
        t_memory();
        t_interrupt_return();
        test_done();
    end
endmodule : ret_rot_exec_tb_top
